// ---- logic/video_lookup_overlay_mux.sv ----
// Operation
// RULE1: each table holds 64 six-bit words; low four address bits pick word in group
// RULE2: upper two address bits decode one-hot to one of four storage groups
// RULE3: tables A and B active per colour, each with own address and write pulse
// RULE4: host write data goes to both tables; enables decide which stores it
// RULE5: two-level mux: A, B, spare, overlay; overlay is cursor or grid fill
// RULE6: mux follows sequencer channel control and may change every pixel
// RULE7: chosen word is latched on the pixel latch strobe, all bits together
// RULE8: during horizontal sync the output latch is forced to zero
// RULE9: single-one mode selects table A; single-two mode selects table B
// RULE10: cursor or grid overrides channel choice; cursor beats grid
// RULE11: cursor drives cursor_fill_select, grid drives grid_fill_select, background colour out
// RULE12: matting mode picks A or B per pixel from matting bit; overlays still win
// RULE13: overlays replace pixel outright; sources are never blended
// RULE14: interlace alternates tables A and B each pixel; overlays stay active
// RULE15: three selectors pick cursor, grid, matting bits from six shared inputs
// RULE16: selector outputs are active low
// RULE17: inputs are cursor bit, level bit, complemented level bit; rest spare
// RULE18: host changes background colours only at frame rate
// RULE19: read bit selects video sample address, write bit selects load counter
// RULE20: with no mode or overlay active, table A is shown
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module video_lookup_overlay_mux (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic [video_mux_pkg::APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timing generator pins
    input wire logic latch_strobe,
    input wire logic hsync,
    // table address sources
    input wire logic [5:0] video_sample_a,
    input wire logic [5:0] video_sample_b,
    input wire logic [5:0] load_addr,
    // overlay sources
    input wire logic cursor_bit,
    input wire logic level_bit,
    input wire logic [2:0] spare_src,
    // converter side
    output video_mux_pkg::rgb_s rgb_out
);
    localparam int unsigned WW = video_mux_pkg::WORD_W;
    localparam int unsigned NC = video_mux_pkg::COLOURS;

    video_mux_pkg::state_s s;
    video_mux_pkg::state_s n;
    video_mux_pkg::pin_s pins_in;
    video_mux_pkg::rgb_s mux_word;
    logic [WW-1:0] mux_c [NC];
    logic [video_mux_pkg::SRC_N-1:0] src;
    logic cursor_n;
    logic grid_n;
    logic matte_n;
    logic cur_on;
    logic grid_on;
    logic matte_on;
    logic strobe_pulse;
    logic [5:0] addr_a;
    logic [5:0] addr_b;
    logic [3:0] grp_a;
    logic [3:0] grp_b;
    logic access;
    logic hit;
    logic [31:0] rdata;
    video_mux_pkg::chan_sel_e sel_next;

    // active-low source pick; codes past the last input read as inactive
    function automatic logic pick_n(input logic [5:0] v, input logic [2:0] k);
        logic r;
        r = 1'b0;
        if (k < 3'h6) begin
            r = v[k];
        end
        return ~r;
    endfunction

    // pin bundle; the sample words are assumed stable around the strobe
    assign pins_in = '{strobe: latch_strobe, hsync: hsync, samp_a: video_sample_a,
                       samp_b: video_sample_b, load_addr: load_addr,
                       cursor_bit: cursor_bit, level_bit: level_bit,
                       spare_src: spare_src};

    assign strobe_pulse = s.pin2.strobe && !s.strobe_d;

    assign src = {s.pin2.spare_src, ~s.pin2.level_bit, s.pin2.level_bit,
                  s.pin2.cursor_bit}; // [RULE17]
    assign cursor_n = pick_n(src, s.ctrl.cursor_src); // [RULE15] [RULE16]
    assign grid_n = pick_n(src, s.ctrl.grid_src); // [RULE15] [RULE16]
    assign matte_n = pick_n(src, s.ctrl.matte_src); // [RULE15] [RULE16]
    assign cur_on = !cursor_n;
    assign grid_on = !grid_n;
    assign matte_on = !matte_n;

    // read wins if software sets both address modes
    assign addr_a = (s.ctrl.wr && !s.ctrl.rd) ? s.pin2.load_addr : s.pin2.samp_a; // [RULE19]
    assign addr_b = (s.ctrl.wr && !s.ctrl.rd) ? s.pin2.load_addr : s.pin2.samp_b; // [RULE19]
    assign grp_a = 4'h1 << addr_a[5:4]; // [RULE2]
    assign grp_b = 4'h1 << addr_b[5:4]; // [RULE2]

    // channel sequencer: cursor, grid, then the data-channel modes
    always_comb begin
        if (cur_on) begin
            sel_next = video_mux_pkg::SEL_CURSOR; // [RULE10] [RULE11]
        end else if (grid_on) begin
            sel_next = video_mux_pkg::SEL_GRID; // [RULE10] [RULE11]
        end else if (s.ctrl.interlace) begin
            sel_next = s.phase ? video_mux_pkg::SEL_B : video_mux_pkg::SEL_A; // [RULE14]
        end else if (s.ctrl.matting) begin
            sel_next = matte_on ? video_mux_pkg::SEL_B : video_mux_pkg::SEL_A; // [RULE12]
        end else if (s.ctrl.single1) begin
            sel_next = video_mux_pkg::SEL_A; // [RULE9]
        end else if (s.ctrl.single2) begin
            sel_next = video_mux_pkg::SEL_B; // [RULE9]
        end else begin
            sel_next = video_mux_pkg::SEL_A; // [RULE20]
        end
    end

    for (genvar c = 0; c < NC; c++) begin : g_colour
        localparam int unsigned HI = NC * WW - 1 - c * WW;
        logic [WW-1:0] tab_a [video_mux_pkg::GROUPS][video_mux_pkg::GROUP_WORDS]; // [RULE1]
        logic [WW-1:0] tab_b [video_mux_pkg::GROUPS][video_mux_pkg::GROUP_WORDS]; // [RULE3]
        logic [WW-1:0] rd_a;
        logic [WW-1:0] rd_b;
        logic [WW-1:0] fill;

        // same data word offered to both tables, each with its own enable
        always_ff @(posedge clk) begin
            for (int g = 0; g < video_mux_pkg::GROUPS; g++) begin
                if (s.we_a && grp_a[g]) begin
                    tab_a[g][addr_a[3:0]] <= s.load_data[HI -: WW]; // [RULE3] [RULE4]
                end
                if (s.we_b && grp_b[g]) begin
                    tab_b[g][addr_b[3:0]] <= s.load_data[HI -: WW]; // [RULE3] [RULE4]
                end
            end
        end

        always_comb begin
            rd_a = '0;
            rd_b = '0;
            for (int g = 0; g < video_mux_pkg::GROUPS; g++) begin
                if (grp_a[g]) begin
                    rd_a = rd_a | tab_a[g][addr_a[3:0]]; // [RULE1] [RULE2]
                end
                if (grp_b[g]) begin
                    rd_b = rd_b | tab_b[g][addr_b[3:0]];
                end
            end
        end

        // second level: cursor or grid fill into the overlay channel
        assign fill = (sel_next == video_mux_pkg::SEL_CURSOR) ?
                      s.bg_cursor[HI -: WW] : s.bg_grid[HI -: WW]; // [RULE5] [RULE11]

        // first level; one source wins outright, no blending
        always_comb begin
            unique case (sel_next)
                video_mux_pkg::SEL_A: mux_c[c] = rd_a; // [RULE5] [RULE13]
                video_mux_pkg::SEL_B: mux_c[c] = rd_b;
                video_mux_pkg::SEL_CURSOR,
                video_mux_pkg::SEL_GRID: mux_c[c] = fill;
                video_mux_pkg::SEL_SPARE: mux_c[c] = '0;
                default: mux_c[c] = '0;
            endcase
        end
    end

    assign mux_word = {mux_c[0], mux_c[1], mux_c[2]};

    assign access = psel && penable;
    assign hit = (paddr == video_mux_pkg::CTRL_OFF) || (paddr == video_mux_pkg::CURSOR_BG_OFF)
                 || (paddr == video_mux_pkg::GRID_BG_OFF) || (paddr == video_mux_pkg::LOAD_OFF)
                 || (paddr == video_mux_pkg::STATUS_OFF);

    always_comb begin
        unique case (paddr)
            video_mux_pkg::CTRL_OFF: rdata = {17'h0, s.ctrl};
            video_mux_pkg::CURSOR_BG_OFF: rdata = {14'h0, s.bg_cursor};
            video_mux_pkg::GRID_BG_OFF: rdata = {14'h0, s.bg_grid};
            video_mux_pkg::LOAD_OFF: rdata = {14'h0, s.load_data};
            video_mux_pkg::STATUS_OFF: rdata = {9'h0, s.pin2.hsync, s.phase, s.sel, s.rgb_out};
            default: rdata = 32'h0;
        endcase
    end

    always_comb begin
        n = s;
        n.pin1 = pins_in;
        n.pin2 = s.pin1;
        n.strobe_d = s.pin2.strobe;
        n.we_a = 1'b0;
        n.we_b = 1'b0;
        // one wait state so read data and pready come from flops
        n.pready = access && !s.pready;
        n.pslverr = access && !s.pready && !hit;
        if (access && !s.pready) begin
            n.prdata = rdata;
        end
        if (access && s.pready && pwrite) begin
            unique case (paddr)
                video_mux_pkg::CTRL_OFF: n.ctrl = pwdata[14:0];
                // host is expected to touch these only between frames
                video_mux_pkg::CURSOR_BG_OFF: n.bg_cursor = pwdata[17:0]; // [RULE18]
                video_mux_pkg::GRID_BG_OFF: n.bg_grid = pwdata[17:0]; // [RULE18]
                video_mux_pkg::LOAD_OFF: begin
                    n.load_data = pwdata[17:0];
                    n.we_a = pwdata[video_mux_pkg::LOAD_EN_A_BIT] && s.ctrl.wr; // [RULE4]
                    n.we_b = pwdata[video_mux_pkg::LOAD_EN_B_BIT] && s.ctrl.wr; // [RULE4]
                end
                default: ;
            endcase
        end
        if (strobe_pulse) begin
            n.phase = ~s.phase; // [RULE14]
            n.sel = sel_next; // [RULE6]
            n.rgb_out = s.pin2.hsync ? '0 : mux_word; // [RULE7] [RULE8]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= video_mux_pkg::STATE_RST;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign rgb_out = s.rgb_out;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence pixel_taken;
        strobe_pulse && !s.pin2.hsync;
    endsequence

    sequence no_overlay;
        !cur_on && !grid_on;
    endsequence

    chk_sync_blank: assert property (strobe_pulse && s.pin2.hsync |=> s.rgb_out == '0) // [RULE8]
        else $error("output not zero in sync");
    chk_out_hold: assert property (!strobe_pulse |=> $stable(s.rgb_out)) // [RULE7]
        else $error("output changed without strobe");
    chk_cursor_fill: assert property (pixel_taken ##0 cur_on |=> // [RULE10]
        s.rgb_out == s.bg_cursor && s.sel == video_mux_pkg::SEL_CURSOR)
        else $error("cursor fill not shown");
    chk_grid_fill: assert property (pixel_taken ##0 (grid_on && !cur_on) |=> // [RULE11]
        s.rgb_out == s.bg_grid && s.sel == video_mux_pkg::SEL_GRID)
        else $error("grid fill not shown");
    chk_single_two: assert property (strobe_pulse ##0 no_overlay ##0 // [RULE9]
        (s.ctrl.single2 && !s.ctrl.single1 && !s.ctrl.interlace && !s.ctrl.matting)
        |=> s.sel == video_mux_pkg::SEL_B)
        else $error("single two did not pick table b");
    chk_default_a: assert property (strobe_pulse ##0 no_overlay ##0 // [RULE20]
        (s.ctrl[3:0] == 4'h0) |=> s.sel == video_mux_pkg::SEL_A)
        else $error("idle mode did not pick table a");
    chk_interlace_alt: assert property (strobe_pulse ##0 no_overlay ##0 s.ctrl.interlace // [RULE14]
        |=> s.sel == ($past(s.phase) ? video_mux_pkg::SEL_B : video_mux_pkg::SEL_A)
        ##1 s.phase != $past(s.phase, 2))
        else $error("interlace did not alternate");
    chk_matte_pick: assert property (strobe_pulse ##0 no_overlay ##0 // [RULE12]
        (s.ctrl.matting && !s.ctrl.interlace)
        |=> s.sel == ($past(matte_on) ? video_mux_pkg::SEL_B : video_mux_pkg::SEL_A))
        else $error("matting pick wrong");
    chk_group_onehot: assert property ($onehot(grp_a) && $onehot(grp_b)) // [RULE2]
        else $error("group select not one-hot");
    chk_apb_wait: assert property (access && !s.pready |=> s.pready ##1 !s.pready)
        else $error("apb answer timing wrong");
    chk_single_one: assert property (strobe_pulse ##0 no_overlay ##0 // [RULE9]
        (s.ctrl.single1 && !s.ctrl.interlace && !s.ctrl.matting)
        |=> s.sel == video_mux_pkg::SEL_A)
        else $error("single one did not pick table a");
    chk_sel_follow: assert property (strobe_pulse |=> s.sel == $past(sel_next)) // [RULE6]
        else $error("channel select not taken at strobe");
    chk_pixel_latch: assert property (pixel_taken |=> s.rgb_out == $past(mux_word)) // [RULE7]
        else $error("selected word not latched");
    chk_phase_flip: assert property (strobe_pulse |=> s.phase != $past(s.phase)) // [RULE14]
        else $error("interlace phase did not toggle");
    chk_load_mode: assert property (s.we_a || s.we_b |-> s.ctrl.wr) // [RULE19]
        else $error("table write outside load mode");
    // an unmapped access answers with an error and zero data
    chk_apb_refuse: assert property (access && !s.pready && !hit
        |=> s.pready && s.pslverr && s.prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_ctrl_write: assert property (access && s.pready && pwrite
        && paddr == video_mux_pkg::CTRL_OFF
        |=> {17'h0, s.ctrl} == ($past(pwdata) & 32'h00007fff))
        else $error("control write not taken");
endmodule // video_lookup_overlay_mux
`default_nettype wire

// ---- logic/video_mux_pkg.sv ----
`default_nettype none
package video_mux_pkg;
    localparam int unsigned WORD_W = 6;
    localparam int unsigned COLOURS = 3;
    localparam int unsigned GROUPS = 4;
    localparam int unsigned GROUP_WORDS = 16;
    localparam int unsigned SRC_N = 6;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned APB_AW = 8;
    // register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] CURSOR_BG_OFF = 8'h04;
    localparam logic [7:0] GRID_BG_OFF = 8'h08;
    localparam logic [7:0] LOAD_OFF = 8'h0c;
    localparam logic [7:0] STATUS_OFF = 8'h10;
    // load register fields
    localparam int unsigned LOAD_EN_A_BIT = 24;
    localparam int unsigned LOAD_EN_B_BIT = 25;
    // output multiplexer channel, gray along a, b, cursor, grid
    typedef enum logic [2:0] {
        SEL_A = 3'h0,
        SEL_B = 3'h1,
        SEL_CURSOR = 3'h3,
        SEL_GRID = 3'h2,
        SEL_SPARE = 3'h6
    } chan_sel_e;
    typedef struct packed {
        logic [5:0] r;
        logic [5:0] g;
        logic [5:0] b;
    } rgb_s;
    // control register, bit 0 = single1 upward
    typedef struct packed {
        logic [2:0] matte_src;
        logic [2:0] grid_src;
        logic [2:0] cursor_src;
        logic wr;
        logic rd;
        logic interlace;
        logic matting;
        logic single2;
        logic single1;
    } ctrl_s;
    typedef struct packed {
        logic strobe;
        logic hsync;
        logic [5:0] samp_a;
        logic [5:0] samp_b;
        logic [5:0] load_addr;
        logic cursor_bit;
        logic level_bit;
        logic [2:0] spare_src;
    } pin_s;
    typedef struct packed {
        ctrl_s ctrl;
        rgb_s bg_cursor;
        rgb_s bg_grid;
        rgb_s load_data;
        logic we_a;
        logic we_b;
        pin_s pin1;
        pin_s pin2;
        logic strobe_d;
        logic phase;
        chan_sel_e sel;
        rgb_s rgb_out;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_s;
    localparam state_s STATE_RST = '0;
endpackage
`default_nettype wire

// ---- testbench/pixel_timing_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pixel_timing_model (
    // clock
    input wire logic clk,
    // bench requests
    input wire logic pulse_req,
    input wire logic sync_req,
    // timing pins
    output logic latch_strobe,
    output logic hsync
);
    logic [2:0] cnt_reg = 3'h0;
    // high three cycles, low four: both phases outlast the pin synchronisers
    always_ff @(posedge clk) begin
        if (pulse_req && cnt_reg == 3'h0) begin
            cnt_reg <= 3'h6;
        end else if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
        end
    end
    assign latch_strobe = cnt_reg > 3'h3;
    assign hsync = sync_req;
endmodule // pixel_timing_model
`default_nettype wire

// ---- testbench/test_video_lookup_overlay_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
`define check(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_video_lookup_overlay_mux;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, latch_strobe, hsync, err;
    logic pulse_req = 1'b0, sync_req = 1'b0, cursor_bit = 1'b0, level_bit = 1'b0;
    logic [5:0] video_sample_a = 6'h0, video_sample_b = 6'h0, load_addr = 6'h0;
    logic [2:0] spare_src = 3'h0;
    logic phase = 1'b0;
    video_mux_pkg::rgb_s rgb_out, last_rgb, bg_c, bg_g;
    video_mux_pkg::rgb_s ta [64], tb [64];
    int failures = 0, samples_checked = 0;
    // corner cases: both overlays, sync blank, grid alone, default, matting, interlace
    localparam logic [14:0] CORNER_CV [8] = '{15'h7010, 15'h7010, 15'h7290, 15'h7010,
        15'h3fd4, 15'h3fd4, 15'h7fda, 15'h7fdd};
    localparam logic [5:0] CORNER_BITS [8] = '{6'h01, 6'h21, 6'h02, 6'h00, 6'h04, 6'h00,
        6'h00, 6'h00};

    video_lookup_overlay_mux dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .latch_strobe(latch_strobe), .hsync(hsync),
        .video_sample_a(video_sample_a), .video_sample_b(video_sample_b), .load_addr(load_addr),
        .cursor_bit(cursor_bit), .level_bit(level_bit), .spare_src(spare_src), .rgb_out(rgb_out));
    pixel_timing_model timing (.clk(clk), .pulse_req(pulse_req), .sync_req(sync_req),
        .latch_strobe(latch_strobe), .hsync(hsync));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            failures++;
            summarize();
        end
        @(posedge clk);
    endtask

    function automatic logic pick(input logic [2:0] s);
        logic [5:0] v;
        v = {spare_src, ~level_bit, level_bit, cursor_bit};
        return s < 3'h6 ? v[s] : 1'b0;
    endfunction

    function automatic video_mux_pkg::rgb_s want(input video_mux_pkg::ctrl_s c);
        if (sync_req) return '0;
        if (pick(c.cursor_src)) return bg_c;
        if (pick(c.grid_src)) return bg_g;
        if (c.interlace ? phase : c.matting ? pick(c.matte_src) : !c.single1 && c.single2)
            return tb[video_sample_b];
        return ta[video_sample_a];
    endfunction

    task automatic pixel(input logic [14:0] cv, input logic [5:0] sa, input logic [5:0] sb,
            input logic [5:0] bits);
        apb(1'b1, video_mux_pkg::CTRL_OFF, {17'h0, cv});
        video_sample_a <= sa;
        video_sample_b <= sb;
        {sync_req, spare_src, level_bit, cursor_bit} <= bits;
        repeat (4) @(posedge clk);
        `check("rgb_hold", last_rgb, rgb_out)
        pulse_req <= 1'b1;
        last_rgb = want(video_mux_pkg::ctrl_s'(cv));
        phase = ~phase;
        @(posedge clk);
        pulse_req <= 1'b0;
        repeat (8) @(posedge clk);
        `check("rgb_out", last_rgb, rgb_out)
    endtask

    initial begin
        int i;
        void'($urandom(32'hc639));
        last_rgb = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, video_mux_pkg::CTRL_OFF, 32'h0);
        `check("ctrl_reset", 32'h0, q)
        apb(1'b0, 8'h14, 32'h0);
        `check("unmapped_err", 1'b1, err)
        `check("unmapped_data", 32'h0, q)
        bg_c = 18'($urandom);
        bg_g = 18'($urandom);
        apb(1'b1, video_mux_pkg::CURSOR_BG_OFF, {14'h0, bg_c});
        apb(1'b1, video_mux_pkg::GRID_BG_OFF, {14'h0, bg_g});
        apb(1'b0, video_mux_pkg::GRID_BG_OFF, 32'h0);
        `check("grid_bg", {14'h0, bg_g}, q)
        $display("test registers done");
        apb(1'b1, video_mux_pkg::CTRL_OFF, 32'h20);
        for (i = 0; i < 64; i++) begin
            load_addr <= 6'(i);
            tb[i] = 18'($urandom);
            ta[i] = 18'($urandom);
            repeat (3) @(posedge clk);
            apb(1'b1, video_mux_pkg::LOAD_OFF, {6'h0, 2'h3, 6'h0, tb[i]});
            apb(1'b1, video_mux_pkg::LOAD_OFF, {6'h0, 2'h1, 6'h0, ta[i]});
        end
        apb(1'b1, video_mux_pkg::CTRL_OFF, 32'h10);
        // in read mode a load latches the data word but leaves both tables untouched
        apb(1'b1, video_mux_pkg::LOAD_OFF, 32'h03ffffff);
        apb(1'b0, video_mux_pkg::LOAD_OFF, 32'h0);
        `check("load_read", 32'h0003ffff, q)
        $display("test load done");
        for (i = 0; i < 64; i++) begin
            pixel({11'h7fd, 2'h0, i[0], ~i[0]}, 6'(i), 6'(63 - i), 6'h00);
        end
        $display("test address sweep done");
        for (i = 0; i < 8; i++) begin
            pixel(CORNER_CV[i], 6'(i), 6'(7 * i), CORNER_BITS[i]);
        end
        $display("test corners done");
        for (i = 0; i < 150; i++) begin
            pixel((15'($urandom) & 15'h7fcf) | 15'h0010, 6'($urandom), 6'($urandom),
                {($urandom % 8 == 0), 5'($urandom)});
        end
        $display("test random done");
        apb(1'b0, video_mux_pkg::STATUS_OFF, 32'h0);
        `check("status_rgb", last_rgb, q[17:0])
        summarize();
    end
endmodule // test_video_lookup_overlay_mux
`default_nettype wire
